// ===== hw/kwport_top.v
// Purpose: Eight-bit general port with per-pin direction and key wake
// Assumes: One 250 MHz clock, pins sampled through two flip-flops
// Notes:   Data latches ignore reset; drive is per pin, pullup on pins 1 to 6 only
`timescale 1ns/10ps
`include "kwport_consts.vh"

module kwport_top
(
  CLOCK,
  NRST,
  ADDR,
  WDATA,
  WR,
  RD,
  RDATA,
  PIN_IN,
  PIN_OUT,
  PIN_OE,
  PIN_PULLUP
);
  input  wire                   CLOCK;
  input  wire                   NRST;
  input  wire [`KWP_ADDR_W-1:0] ADDR;
  input  wire [7:0]             WDATA;
  input  wire                   WR;
  input  wire                   RD;
  output reg  [7:0]             RDATA;
  input  wire [7:0]             PIN_IN;
  output reg  [7:0]             PIN_OUT;
  output reg  [7:0]             PIN_OE;
  output reg  [7:0]             PIN_PULLUP;

  //////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  reg        rst_meta_q;
  reg        rst_n_q;
  reg  [7:0] pin_meta_q;
  reg  [7:0] pin_sync_q;

  always @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always @(posedge CLOCK)
  begin
    pin_meta_q <= PIN_IN;
    pin_sync_q <= pin_meta_q;
  end

  //////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0] port_pin_latch_q;
  reg  [7:0] port_direction_bits_q;
  reg  [7:0] key_wake_enable_bits_q;
  reg        latch_init_q;

  function hit;
    input [`KWP_ADDR_W-1:0] a;
    input [`KWP_ADDR_W-1:0] ofs;
    input                   stb;
    begin
      hit = stb && (a == ofs);
    end
  endfunction

  // Latch has no reset; one-time power-up preset keeps sim defined
  initial latch_init_q = 1'b0;
  always @(posedge CLOCK)
  begin
    if (hit(ADDR, `KWP_OFS_LATCH, WR))
      port_pin_latch_q <= WDATA;
    else if (!latch_init_q)
      port_pin_latch_q <= `KWP_LATCH_POWERUP;
    latch_init_q <= 1'b1;
  end

  always @(posedge CLOCK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      port_direction_bits_q  <= `KWP_DIR_RESET;
      key_wake_enable_bits_q <= `KWP_WAKE_RESET;
    end
    else
    begin
      if (hit(ADDR, `KWP_OFS_DIR, WR))
        port_direction_bits_q <= WDATA;
      if (hit(ADDR, `KWP_OFS_WAKE, WR))
        key_wake_enable_bits_q <= WDATA & `KWP_WAKE_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin control
  wire [7:0] drive_w = port_direction_bits_q & ~key_wake_enable_bits_q;

  always @(posedge CLOCK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      PIN_OE     <= 8'h00;
      PIN_OUT    <= 8'h00;
      PIN_PULLUP <= 8'h00;
    end
    else
    begin
      PIN_OE     <= drive_w;
      PIN_OUT    <= port_pin_latch_q;
      PIN_PULLUP <= key_wake_enable_bits_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  reg [7:0] rdata_d;
  always @*
  begin
    rdata_d = 8'h00;
    if (RD)
    begin
      case (ADDR)
        // Wake-enabled pins are inputs, so they read the pin
        `KWP_OFS_LATCH: rdata_d = (drive_w & port_pin_latch_q)
                                | (~drive_w & pin_sync_q);
        `KWP_OFS_DIR:   rdata_d = port_direction_bits_q;
        `KWP_OFS_WAKE:  rdata_d = key_wake_enable_bits_q;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge CLOCK or negedge rst_n_q)
  begin
    if (!rst_n_q)
      RDATA <= 8'h00;
    else
      RDATA <= rdata_d;
  end

endmodule // kwport_top

// ===== hw/kwport_consts.vh
// Purpose: Constants for the eight-bit port with key wake
// Assumes: Plain register port, byte-wide data
// Notes:   Offsets are register indices on the plain port
`ifndef KWPORT_CONSTS_VH
`define KWPORT_CONSTS_VH
`define KWP_ADDR_W        4
`define KWP_OFS_LATCH     4'h0
`define KWP_OFS_DIR       4'h4
`define KWP_OFS_WAKE      4'h5
`define KWP_DIR_RESET     8'h00
`define KWP_WAKE_RESET    8'h00
`define KWP_WAKE_MASK     8'h7e
`define KWP_LATCH_POWERUP 8'h00
`endif

// ===== test/kwport_asserts.sv
// Purpose: Port checker
// Assumes: Bound to kwport_top
// Notes:   Pins lag writes by two edges
`timescale 1ns/10ps
module kwport_chk
(
  input wire       CLOCK, NRST, WR, RD,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA, RDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence dir_wr; WR && ADDR == 4'h4 ##2 PIN_PULLUP == 8'h00; endsequence
  sequence rd_q; RD && ADDR == 4'h0 && !$past(WR); endsequence
  pu_edge_a: assert property ((PIN_PULLUP & 8'h81) == 8'h00)
    else $error("pullup edge");
  wake_oe_a: assert property ((PIN_OE & PIN_PULLUP) == 8'h00)
    else $error("wake oe");
  wake_wr_a: assert property (WR && ADDR == 4'h5 |-> ##2
    PIN_PULLUP == ($past(WDATA, 2) & 8'h7e)) else $error("wake wr");
  dir_wr_a: assert property (dir_wr |-> PIN_OE == $past(WDATA, 2))
    else $error("dir wr");
  latch_wr_a: assert property (WR && ADDR == 4'h0 |-> ##2
    PIN_OUT == $past(WDATA, 2)) else $error("latch wr");
  rd_out_a: assert property (rd_q and PIN_OE == 8'hff |=>
    RDATA == $past(PIN_OUT)) else $error("rd out");
  rd_in_a: assert property (rd_q and (PIN_OE | PIN_PULLUP) == 8'h00
    |=> RDATA == $past(PIN_IN, 3)) else $error("rd in");
endmodule // kwport_chk
bind kwport_top kwport_chk i_chk(.*);

// ===== test/tb_kwport_top.sv
// Purpose: Bench for kwport_top
// Assumes: Latch 0, direction 4, wake 5
// Notes:   Latch must survive reset
`timescale 1ns/10ps
module tb_kwport_top;
  reg        CLOCK = 0, NRST = 0, WR = 0, RD = 0;
  reg  [3:0] ADDR = 0;
  reg  [7:0] WDATA = 0, PIN_IN = 0;
  wire [7:0] RDATA, PIN_OUT, PIN_OE, PIN_PULLUP;
  integer    mismatches = 0, n_tests = 0, cyc = 0, i;
  reg [39:0] rows [0:3];
  kwport_top i_dut(.*);
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK)
    if (++cyc == 1000)
    begin
      mismatches++;
      give_verdict;
    end
  task chk(input [7:0] s, e, input [8*5:1] n);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected %0s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge CLOCK);
    {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLOCK);
    WR <= 0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge CLOCK);
    {ADDR, RD} <= {a, 1'b1};
    @(posedge CLOCK);
    RD <= 0;
    #1 chk(RDATA, e, "rdata");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Rows: direction, wake, latch, pins, read data
  initial
  begin
    rows[0] = 40'hff_00_a5_3c_a5;
    rows[1] = 40'h00_00_a5_3c_3c;
    rows[2] = 40'h0f_ff_a5_3c_3d;
    rows[3] = 40'hf0_7e_c3_5a_da;
    repeat (6) @(posedge CLOCK);
    NRST <= 1;
    repeat (3) @(posedge CLOCK);
    for (i = 0; i < 4; i++)
    begin
      PIN_IN <= rows[i][15:8];
      wr(4'h4, rows[i][39:32]);
      wr(4'h5, rows[i][31:24]);
      wr(4'h0, rows[i][23:16]);
      rd(4'h0, rows[i][7:0]);
      chk(PIN_PULLUP, rows[i][31:24] & 8'h7e, "pu");
      chk(PIN_OE, rows[i][39:32] & ~(rows[i][31:24] & 8'h7e), "oe");
      chk(PIN_OUT, rows[i][23:16], "out");
    end
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h00);
    @(posedge CLOCK);
    NRST <= 0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1;
    repeat (3) @(posedge CLOCK);
    chk(PIN_OE, 8'h00, "oe");
    wr(4'h4, 8'hff);
    rd(4'h0, 8'hc3);
    give_verdict;
  end
endmodule // tb_kwport_top
